// File: design/sbicf_fair_limiter.v
// Counts priority requests per fairness interval and blocks above the limit
module sbicf_fair_limiter #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// Control
	input  wire [WIDTH-1:0] limit,
	input  wire             interval_start,
	input  wire             pri_req_want,
	// Status
	output wire             pri_req_allow,
	output wire [WIDTH-1:0] used_count
);

	reg  [WIDTH-1:0] cnt_ff;
	reg  [WIDTH-1:0] nxt_cnt;
	wire [WIDTH-1:0] base_cnt;

	// A request in the cycle of an interval start spends the new budget,
	// so the start cannot hand out one grant beyond the limit
	assign base_cnt      = interval_start ? {WIDTH{1'b0}} : cnt_ff;
	// A limit of zero allows no priority requests at all
	assign pri_req_allow = pri_req_want && (base_cnt < limit); // [R05]
	assign used_count    = cnt_ff;

	always @* begin
		nxt_cnt = base_cnt;
		if (pri_req_allow)
			nxt_cnt = base_cnt + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always @(posedge aclk) begin
		if (!aresetn)
			cnt_ff <= {WIDTH{1'b0}};
		else
			cnt_ff <= nxt_cnt;
	end

endmodule

// File: design/sbicf_regs.v
// How it works
// R01: System or software reset sets both initial channel registers to ones.
// R02: Serial-bus reset leaves the initial channel registers untouched.
// R03: Any qualifying reset copies the high initial value into CSR high.
// R04: Any qualifying reset copies the low initial value into CSR low.
// R05: Priority requests per fairness interval never exceed the 8-bit limit.
// R06: Fairness limit resets to zero; whole register reads zero.
// R07: Fairness bits 31 to 8 read zero and ignore writes.
// R08: Link control is reached at a set view E0h and clear view E4h.
// R09: Link control bits 22-20 and 10-9 are don't-care after reset, rest zero.
// R10: Writing one at set view sets, at clear view clears; zeros do nothing.
// R11: Reads at either link control view return the current contents.
// R12: Writes to initial registers reach the CSRs only at the next reset load.
`include "sbicf_defs.vh"

module sbicf_regs (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Reset events
	input  wire        soft_reset,
	input  wire        global_reset_pin,
	input  wire        pcie_reset_pin,
	input  wire        pci_bus_reset_pin,
	input  wire        serial_bus_reset,
	// Fairness interface to the link
	input  wire        fairness_interval_start,
	input  wire        pri_req_want,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Outputs to the link
	output reg  [31:0] csr_channels_high,
	output reg  [31:0] csr_channels_low,
	output reg  [31:0] link_control,
	output reg         pri_req_grant
);

	////////////////////////////////////////////////////////////////////////
	// Reset-event synchronisers (pins are outside the clock domain)

	reg  [3:0] evt_meta_ff;
	reg  [3:0] evt_sync_ff;
	reg        sys_prev_ff;
	reg        load_prev_ff;
	wire       sys_evt;
	wire       load_evt;

	always @(posedge aclk) begin
		if (!aresetn) begin
			evt_meta_ff <= 4'h0;
			evt_sync_ff <= 4'h0;
		end else begin
			evt_meta_ff <= {global_reset_pin, pcie_reset_pin,
			                pci_bus_reset_pin, serial_bus_reset};
			evt_sync_ff <= evt_meta_ff;
		end
	end

	// Software reset is a same-domain level
	assign sys_evt  = soft_reset;
	assign load_evt = |evt_sync_ff | soft_reset;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sys_prev_ff  <= 1'b0;
			load_prev_ff <= 1'b0;
		end else begin
			sys_prev_ff  <= sys_evt;
			load_prev_ff <= load_evt;
		end
	end

	// Copy happens once as the last active reset event is released
	wire load_fire = load_prev_ff && !load_evt;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// One select code per register offset
	localparam SEL_NONE     = 3'h0;
	localparam SEL_INIT_HI  = 3'h1;
	localparam SEL_INIT_LO  = 3'h2;
	localparam SEL_FAIR     = 3'h3;
	localparam SEL_LINK_SET = 3'h4;
	localparam SEL_LINK_CLR = 3'h5;
	localparam SEL_CSR_HI   = 3'h6;
	localparam SEL_CSR_LO   = 3'h7;

	// Write, read and response paths share one map so they cannot drift
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			if (a == `SBICF_OFF_INIT_HI)
				reg_sel = SEL_INIT_HI;
			else if (a == `SBICF_OFF_INIT_LO)
				reg_sel = SEL_INIT_LO;
			else if (a == `SBICF_OFF_FAIRNESS)
				reg_sel = SEL_FAIR;
			else if (a == `SBICF_OFF_LINK_SET)
				reg_sel = SEL_LINK_SET;
			else if (a == `SBICF_OFF_LINK_CLR)
				reg_sel = SEL_LINK_CLR;
			else if (a == `SBICF_OFF_CSR_HI)
				reg_sel = SEL_CSR_HI;
			else if (a == `SBICF_OFF_CSR_LO)
				reg_sel = SEL_CSR_LO;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel

	reg        aw_held_ff;
	reg        w_held_ff;
	reg [7:0]  aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0]  w_strb_ff;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_go   = aw_held_ff && w_held_ff && !s_axi_bvalid;

	function [31:0] strb_mask;
		input [3:0] s;
		begin
			strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  s;
		begin
			merge = (old_v & ~strb_mask(s)) | (new_v & strb_mask(s));
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (reg_sel(a) != SEL_NONE);
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SBICF_RESP_OKAY;
		end else begin
			// Each channel accepted independently, one word at a time
			s_axi_awready <= !aw_held_ff && !aw_take && !s_axi_awready;
			s_axi_wready  <= !w_held_ff && !w_take && !s_axi_wready;
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr_ff) ? `SBICF_RESP_OKAY
				                                   : `SBICF_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage

	reg [31:0] init_hi_ff;
	reg [31:0] init_lo_ff;
	reg [7:0]  fair_limit_ff;
	reg [31:0] nxt_init_hi;
	reg [31:0] nxt_init_lo;
	reg [7:0]  nxt_fair_limit;
	reg [31:0] nxt_link;
	reg [31:0] wmask;
	wire [2:0] wr_sel;

	assign wr_sel = reg_sel(aw_addr_ff);

	always @* begin
		nxt_init_hi    = init_hi_ff;
		nxt_init_lo    = init_lo_ff;
		nxt_fair_limit = fair_limit_ff;
		nxt_link       = link_control;
		wmask          = strb_mask(w_strb_ff) & w_data_ff;
		if (wr_go) begin
			if (wr_sel == SEL_INIT_HI)
				nxt_init_hi = merge(init_hi_ff, w_data_ff, w_strb_ff);
			else if (wr_sel == SEL_INIT_LO)
				nxt_init_lo = merge(init_lo_ff, w_data_ff, w_strb_ff);
			else if (wr_sel == SEL_FAIR) begin
				// Upper bits are not stored at all
				if (w_strb_ff[0])
					nxt_fair_limit = w_data_ff[`SBICF_FAIR_MSB:0]; // [R07]
			end else if (wr_sel == SEL_LINK_SET)
				nxt_link = link_control | (wmask & `SBICF_LINK_MASK); // [R10]
			else if (wr_sel == SEL_LINK_CLR)
				nxt_link = link_control & ~(wmask & `SBICF_LINK_MASK); // [R10]
		end
		// Software reset restores defaults; serial-bus reset does not
		if (sys_evt) begin // [R02]
			nxt_init_hi    = `SBICF_RST_INIT; // [R01]
			nxt_init_lo    = `SBICF_RST_INIT; // [R01]
			nxt_fair_limit = `SBICF_RST_FAIRNESS;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			init_hi_ff    <= `SBICF_RST_INIT; // [R01]
			init_lo_ff    <= `SBICF_RST_INIT; // [R01]
			fair_limit_ff <= `SBICF_RST_FAIRNESS; // [R06]
			// Undefined bits are driven to zero for determinism
			link_control  <= `SBICF_RST_LINK; // [R09]
		end else begin
			init_hi_ff    <= nxt_init_hi;
			init_lo_ff    <= nxt_init_lo;
			fair_limit_ff <= nxt_fair_limit;
			link_control  <= nxt_link;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus-management CSR copies

	// Loaded only on a reset event, so writes to the initial registers
	// stay invisible to the bus until then
	always @(posedge aclk) begin
		if (!aresetn) begin
			csr_channels_high <= `SBICF_RST_INIT;
			csr_channels_low  <= `SBICF_RST_INIT;
		end else if (load_fire) begin // [R12]
			csr_channels_high <= init_hi_ff; // [R03]
			csr_channels_low  <= init_lo_ff; // [R04]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fairness limiter

	wire allow;

	sbicf_fair_limiter #(
		.WIDTH (8)
	) u_limiter (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.limit          (fair_limit_ff),
		.interval_start (fairness_interval_start),
		.pri_req_want   (pri_req_want),
		.pri_req_allow  (allow),
		.used_count     ()
	);

	// Registered grant adds a cycle but keeps the output glitch free
	always @(posedge aclk) begin
		if (!aresetn)
			pri_req_grant <= 1'b0;
		else
			pri_req_grant <= allow; // [R05]
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel

	reg [31:0] rd_val;
	wire [2:0] rd_sel;

	assign rd_sel = reg_sel(s_axi_araddr);

	always @* begin
		rd_val = 32'h00000000;
		if (rd_sel == SEL_INIT_HI)
			rd_val = init_hi_ff;
		else if (rd_sel == SEL_INIT_LO)
			rd_val = init_lo_ff;
		else if (rd_sel == SEL_FAIR)
			rd_val = {24'h000000, fair_limit_ff}; // [R06] [R07]
		else if (rd_sel == SEL_LINK_SET || rd_sel == SEL_LINK_CLR)
			rd_val = link_control; // [R08] [R11]
		else if (rd_sel == SEL_CSR_HI)
			rd_val = csr_channels_high;
		else if (rd_sel == SEL_CSR_LO)
			rd_val = csr_channels_low;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SBICF_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= mapped(s_axi_araddr) ? `SBICF_RESP_OKAY
				                                     : `SBICF_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// File: dv/sbicf_regs_properties.sv
module sbicf_regs_properties (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Reset events
	input logic        soft_reset,
	input logic        global_reset_pin,
	input logic        pcie_reset_pin,
	input logic        pci_bus_reset_pin,
	input logic        serial_bus_reset,
	// Link side
	input logic        pri_req_want,
	input logic        pri_req_grant,
	// Read channel
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	// Register images
	input logic [31:0] csr_channels_high,
	input logic [31:0] csr_channels_low,
	input logic [31:0] link_control
);
	logic [7:0] rd_addr_ff;
	logic       any_rst;

	assign any_rst = soft_reset | global_reset_pin | pcie_reset_pin
		| pci_bus_reset_pin | serial_bus_reset;

	// Address of the read in flight, so read data can be judged
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			rd_addr_ff <= s_axi_araddr;
	end

	////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rst_csr_a: assert property (
		$rose(aresetn) |-> (csr_channels_high & csr_channels_low) == '1)
		else $error("csr copies not all ones after reset");
	soft_load_a: assert property (
		$fell(soft_reset) |-> ##[1:4]
		(csr_channels_high & csr_channels_low) == '1)
		else $error("csr copies not reloaded after soft reset");
	// Six quiet cycles cover the pin synchroniser delay
	csr_quiet_a: assert property (!any_rst [*6] |=>
		$stable(csr_channels_high) && $stable(csr_channels_low))
		else $error("csr copy moved without a reset event");
	link_rst_a: assert property (
		$rose(aresetn) |-> link_control == 32'h0)
		else $error("link control not zero after reset");
	link_bits_a: assert property (
		(link_control & ~32'h00700640) == 32'h0)
		else $error("reserved link control bit set");
	grant_cause_a: assert property (
		pri_req_grant |-> $past(pri_req_want))
		else $error("grant without a request");
	fair_rsvd_a: assert property (
		s_axi_rvalid && rd_addr_ff == 8'hdc |-> s_axi_rdata[31:8] == 0)
		else $error("fairness reserved bits not zero");
	link_read_a: assert property (
		$rose(s_axi_rvalid) && (rd_addr_ff == 8'he0 || rd_addr_ff == 8'he4)
		|-> s_axi_rdata == $past(link_control) && s_axi_rresp == 2'h0)
		else $error("link control view read wrong");
endmodule

bind sbicf_regs sbicf_regs_properties u_props (.*);

// File: dv/serial_bus_init_channel_fairness_regs_test.sv
module serial_bus_init_channel_fairness_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk = 0, aresetn = 0, soft_reset = 0;
	logic        global_reset_pin, pcie_reset_pin;
	logic        pci_bus_reset_pin, serial_bus_reset;
	logic [3:0]  pins = 4'h0;
	logic        fairness_interval_start = 0, pri_req_want = 0;
	logic        pri_req_grant;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [31:0] csr_channels_high, csr_channels_low, link_control;
	int          n_fail = 0, comparisons = 0, n;

	typedef struct {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [7:0]  ra;
		logic [31:0] rd;
		logic [1:0]  rs;
	} sbicf_row_t;
	// Last row is unmapped: refused with no effect
	sbicf_row_t rows [9] = '{
		'{8'hb4, 32'h12345678, 4'hf, 8'hb4, 32'h12345678, 2'h0},
		'{8'hb8, 32'ha5a5a5a5, 4'hf, 8'hb8, 32'ha5a5a5a5, 2'h0},
		'{8'hb8, 32'ha5ffffa5, 4'h9, 8'hb8, 32'ha5a5a5a5, 2'h0},
		'{8'hdc, 32'hffffff3c, 4'hf, 8'hdc, 32'h0000003c, 2'h0},
		'{8'hdc, 32'h00000077, 4'he, 8'hdc, 32'h0000003c, 2'h0},
		'{8'he0, 32'hffffffff, 4'hf, 8'he4, 32'h00700640, 2'h0},
		'{8'he4, 32'h00300200, 4'hf, 8'he0, 32'h00400440, 2'h0},
		'{8'he4, 32'h00000000, 4'hf, 8'he4, 32'h00400440, 2'h0},
		'{8'h10, 32'hffffffff, 4'hf, 8'h10, 32'h00000000, 2'h2}};

	assign {global_reset_pin, pcie_reset_pin, pci_bus_reset_pin,
		serial_bus_reset} = pins;

	sbicf_regs u_dut (.*);

	always #5 aclk = ~aclk;

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	// Address and data are released each on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		r = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#100us;
		n_fail++;
		close_out;
	end

	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd, rows[i].ws);
			chk(r, rows[i].rs);
			rd(rows[i].ra);
			chk(d, rows[i].rd);
			chk(r, rows[i].rs);
		end
		// Each pin reset reloads the copies; init values survive it
		for (int i = 0; i < 4; i++) begin
			wr(8'hb4, 32'h11111111 * (i + 1), 4'hf);
			chk(csr_channels_high, i ? 32'h11111111 * i : '1);
			pins <= 4'h1 << i;
			repeat (2) @(posedge aclk);
			pins <= 4'h0;
			repeat (8) @(posedge aclk);
			chk(csr_channels_high, 32'h11111111 * (i + 1));
			chk(csr_channels_low, 32'ha5a5a5a5);
			rd(8'hb4);
			chk(d, 32'h11111111 * (i + 1));
		end
		soft_reset <= 1;
		repeat (2) @(posedge aclk);
		soft_reset <= 0;
		repeat (8) @(posedge aclk);
		chk(csr_channels_high, '1);
		rd(8'hb8);
		chk(d, '1);
		wr(8'hdc, 32'h3, 4'h1);
		pri_req_want <= 1;
		// A request in the start cycle itself must count against the limit
		repeat (2) begin
			fairness_interval_start <= 1;
			@(posedge aclk);
			fairness_interval_start <= 0;
			n = 0;
			repeat (8) begin
				@(posedge aclk);
				n += pri_req_grant;
			end
			chk(n, 3);
		end
		pri_req_want <= 0;
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(8'hb4);
		chk(d, '1);
		rd(8'hdc);
		chk(d, 0);
		rd(8'he0);
		chk(d, 0);
		// Zero limit after reset grants nothing
		pri_req_want <= 1;
		n = 0;
		repeat (4) begin
			@(posedge aclk);
			n += pri_req_grant;
		end
		pri_req_want <= 0;
		chk(n, 0);
		close_out;
	end
endmodule

// File: include/sbicf_defs.vh
`ifndef SBICF_DEFS_VH
`define SBICF_DEFS_VH

// Register byte offsets
`define SBICF_OFF_INIT_HI      8'hb4
`define SBICF_OFF_INIT_LO      8'hb8
`define SBICF_OFF_FAIRNESS     8'hdc
`define SBICF_OFF_LINK_SET     8'he0
`define SBICF_OFF_LINK_CLR     8'he4
`define SBICF_OFF_CSR_HI       8'hf0
`define SBICF_OFF_CSR_LO       8'hf4

// Reset values
`define SBICF_RST_INIT         32'hffffffff
`define SBICF_RST_FAIRNESS     8'h00
`define SBICF_RST_LINK         32'h00000000

// Field layout
`define SBICF_FAIR_MSB         7
`define SBICF_LINK_MASK        32'h00700640

// AXI responses
`define SBICF_RESP_OKAY        2'b00
`define SBICF_RESP_SLVERR      2'b10

`endif
